// ===== odc_defines.svh
/*
 Constants of the output driver configuration bank: register indices and byte
 addresses, field positions, reset values, write masks and decode figures.
 Assumes nothing; it is included by the package and by the top module.
*/
`ifndef ODC_DEFINES_SVH
`define ODC_DEFINES_SVH

// ---------------------------------------------------------------
// register indices and byte addresses (index times four)
// ---------------------------------------------------------------
`define ODC_IDX_OUT0 8'h1f
`define ODC_IDX_OUT1 8'h20
`define ODC_ADDR_OUT0 ({22'h000000, `ODC_IDX_OUT0, 2'h0})
`define ODC_ADDR_OUT1 ({22'h000000, `ODC_IDX_OUT1, 2'h0})

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ODC_RSV_HI_BIT 7
`define ODC_SEL_HI 6
`define ODC_SEL_LO 5
`define ODC_M1_HI 4
`define ODC_M1_LO 3
`define ODC_M2_HI 2
`define ODC_M2_LO 1
`define ODC_RSV_LO_BIT 0

// ---------------------------------------------------------------
// reset values and write masks
// ---------------------------------------------------------------
`define ODC_RST_SEL 2'h1
`define ODC_RST_M1 2'h2
`define ODC_RST_M2 2'h0
`define ODC_RST_OUT0 8'hb0
`define ODC_RST_OUT1 8'h30
`define ODC_WMASK_OUT0 8'hfe
`define ODC_WMASK_OUT1 8'h7e

// ---------------------------------------------------------------
// decode figures and bus codes
// ---------------------------------------------------------------
`define ODC_MA_4 5'h04
`define ODC_MA_6 5'h06
`define ODC_MA_8 5'h08
`define ODC_MA_16 5'h10
`define ODC_OHM_50 8'h32
`define ODC_OHM_100 8'h64
`define ODC_OHM_200 8'hc8
`define ODC_HTRANS_NONSEQ 2'h2
`define ODC_HRESP_OKAY 1'h0

`endif

// ===== odc_pkg.sv
/*
 Types and decode functions of the output driver configuration bank.
 Assumes the constants header is on the include path.
*/
`include "odc_defines.svh"

package odc_pkg;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ODC_FMT_OFF = 2'b00,
      ODC_FMT_AC_DIFF = 2'b01,
      ODC_FMT_HCSL = 2'b10,
      ODC_FMT_CMOS = 2'b11
   } odc_format_t;

   // one single-ended leg in cmos format
   typedef struct packed {
      logic powered;
      logic drive_en;
      logic invert;
   } odc_leg_t;

   typedef struct packed {
      odc_format_t fmt;
      logic [4:0] tail_ma;
      logic [7:0] load_ohm;
      odc_leg_t leg_p;
      odc_leg_t leg_n;
   } odc_drive_t;

   // ---------------------------------------------------------------
   // decode functions
   // ---------------------------------------------------------------
   // tail current only exists in the two differential formats
   function automatic logic [4:0] odc_tail_ma(odc_format_t f, logic [1:0] m1);
      logic [4:0] ma;
      ma = 5'h00;
      if (f == ODC_FMT_AC_DIFF || f == ODC_FMT_HCSL) begin
         case (m1)
            2'h0: ma = `ODC_MA_4;
            2'h1: ma = `ODC_MA_6;
            2'h2: ma = `ODC_MA_8;
            default: ma = (f == ODC_FMT_HCSL) ? `ODC_MA_16 : `ODC_MA_8;
         endcase
      end
      return ma;
   endfunction

   // zero stands for a tristated load
   function automatic logic [7:0] odc_load_ohm(odc_format_t f, logic [1:0] m2);
      logic [7:0] ohm;
      ohm = 8'h00;
      if (f == ODC_FMT_HCSL) begin
         case (m2)
            2'h1: ohm = `ODC_OHM_50;
            2'h2: ohm = `ODC_OHM_100;
            2'h3: ohm = `ODC_OHM_200;
            default: ohm = 8'h00;
         endcase
      end
      return ohm;
   endfunction

   // same four codes for both legs; off unless the format is cmos
   function automatic odc_leg_t odc_leg(odc_format_t f, logic [1:0] m);
      odc_leg_t leg;
      leg = '0;
      if (f == ODC_FMT_CMOS) begin
         leg.powered = m[1];
         leg.drive_en = (m != 2'h0);
         leg.invert = (m == 2'h2);
      end
      return leg;
   endfunction

endpackage

// ===== odc_cfg_if.sv
/*
 Field carrier from a channel register to its driver decoder.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface odc_cfg_if;
   logic [1:0] fmt;
   logic [1:0] mode1;
   logic [1:0] mode2;
   modport src (output fmt, output mode1, output mode2);
   modport dst (input fmt, input mode1, input mode2);
endinterface

`default_nettype wire

// ===== odc_chan_reg.sv
/*
 One 8-bit channel control register with a write mask; bits outside the mask
 hold their reset value, which must be zero there.
 Assumes write and restore strobes come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module odc_chan_reg #(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] WR_MASK = 8'hff
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // update strobes
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic restore,
   input wire logic [7:0] restore_data,
   // register state
   output logic [7:0] q,
   output logic [7:0] next_q
);
   import odc_pkg::*;

   // ---------------------------------------------------------------
   // elaboration check
   // ---------------------------------------------------------------
   if ((RESET_VAL & ~WR_MASK) != 8'h00) begin : g_bad_mask
      $error("odc_chan_reg: reset value sets bits outside the write mask");
   end

   // ---------------------------------------------------------------
   // next value: bus write beats a restore in the same cycle
   // ---------------------------------------------------------------
   always_comb begin
      next_q = q;
      if (wr_en) begin
         next_q = (q & ~WR_MASK) | (wr_data & WR_MASK);
      end else if (restore) begin
         next_q = (q & ~WR_MASK) | (restore_data & WR_MASK);
      end
   end

   // register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= RESET_VAL;
      end else begin
         q <= next_q;
      end
   end

endmodule

`default_nettype wire

// ===== odc_drv_decode.sv
/*
 Registered decode of one channel's fields into driver settings.
 Assumes the fields arrive from a register on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module odc_drv_decode (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // fields in
   odc_cfg_if.dst cfg,
   // driver settings
   output odc_pkg::odc_drive_t drv
);
   import odc_pkg::*;

   odc_format_t fmt;
   logic live;
   assign fmt = odc_format_t'(cfg.fmt);

   // checks wait until the decode has loaded once from released registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         live <= 1'b0;
      end else begin
         live <= 1'b1;
      end
   end

   // one flop stage so the analog controls never see decode glitches
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         drv <= '0;
      end else begin
         drv.fmt <= fmt;
         drv.tail_ma <= odc_tail_ma(fmt, cfg.mode1);
         drv.load_ohm <= odc_load_ohm(fmt, cfg.mode2);
         drv.leg_p <= odc_leg(fmt, cfg.mode1);
         drv.leg_n <= odc_leg(fmt, cfg.mode2);
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_TAIL_HCSL16: assert property (@(posedge hclk) disable iff (!hresetn)
      (live && fmt == ODC_FMT_HCSL && cfg.mode1 == 2'h3) |=> drv.tail_ma == `ODC_MA_16)
      else $error("hcsl code 3 did not give 16 mA");
   AST_TAIL_AC8: assert property (@(posedge hclk) disable iff (!hresetn)
      (live && fmt == ODC_FMT_AC_DIFF && cfg.mode1[1]) |=> drv.tail_ma == `ODC_MA_8)
      else $error("ac code 2 or 3 did not give 8 mA");

endmodule

`default_nettype wire

// ===== odc_out_driver_regs.sv
/*
 Output driver configuration bank for channels 0 and 1: two control
 registers on an AHB-Lite slave, a nonvolatile image port and registered
 driver settings for each channel.
 Assumes a single AHB-Lite master doing word transfers, and a nonvolatile
 store on the same clock that restores the image with a one-cycle strobe.
*/
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "odc_defines.svh"

module odc_out_driver_regs (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // nonvolatile image
   input wire logic nv_restore,
   input wire logic [1:0][7:0] nv_image,
   output logic [1:0][7:0] nv_save,
   // driver settings, index is the channel
   output odc_pkg::odc_drive_t [1:0] drv,
   output logic pair_fully_off
);
   import odc_pkg::*;

   localparam logic [31:0] ADDR_OUT0 = `ODC_ADDR_OUT0;
   localparam logic [31:0] ADDR_OUT1 = `ODC_ADDR_OUT1;

   logic dp_write;
   logic dp_read;
   logic [31:0] dp_addr;
   logic [1:0][7:0] ctl;
   logic [1:0][7:0] next_ctl;
   logic [1:0] wr_hit;
   logic addr_take;
   logic seen_clock;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   // full 32-bit compare so no alias of the bank appears elsewhere
   function automatic logic [1:0] reg_hit(logic [31:0] a);
      return {a == ADDR_OUT1, a == ADDR_OUT0};
   endfunction

   // read mux; unmapped words read as zero
   function automatic logic [31:0] reg_read(logic [31:0] a, logic [1:0][7:0] r);
      logic [1:0] h;
      logic [31:0] d;
      h = reg_hit(a);
      d = 32'h00000000;
      if (h[0]) begin
         d = {24'h000000, r[0]};
      end else if (h[1]) begin
         d = {24'h000000, r[1]};
      end
      return d;
   endfunction

   // ---------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // ---------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp = `ODC_HRESP_OKAY;
   // hsize is not checked: every transfer is taken as a whole word
   assign addr_take = hsel && hready && htrans[1];

   // data-phase bookkeeping
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_read <= 1'b0;
         dp_addr <= 32'h00000000;
      end else if (hready) begin
         dp_write <= addr_take && hwrite;
         dp_read <= addr_take && !hwrite;
         if (addr_take) begin
            dp_addr <= haddr;
         end
      end
   end

   assign wr_hit = dp_write ? reg_hit(dp_addr) : 2'b00;

   // read data is a flop loaded at the address edge; it reads the value the
   // registers take at that edge, so a write just before is not missed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (addr_take && !hwrite) begin
         hrdata <= reg_read(haddr, next_ctl);
      end
   end

   // ---------------------------------------------------------------
   // channel registers
   // ---------------------------------------------------------------
   // channel 0: bit 7 is a stored writable bit, bit 0 is fixed at zero
   odc_chan_reg #(
      .RESET_VAL(`ODC_RST_OUT0),
      .WR_MASK(`ODC_WMASK_OUT0)
   ) u_out0 (
      .hclk(hclk),
      .hresetn(hresetn),
      .wr_en(wr_hit[0]),
      .wr_data(hwdata[7:0]),
      .restore(nv_restore),
      .restore_data(nv_image[0]),
      .q(ctl[0]),
      .next_q(next_ctl[0])
   );

   // channel 1: bits 7 and 0 are fixed at zero
   odc_chan_reg #(
      .RESET_VAL(`ODC_RST_OUT1),
      .WR_MASK(`ODC_WMASK_OUT1)
   ) u_out1 (
      .hclk(hclk),
      .hresetn(hresetn),
      .wr_en(wr_hit[1]),
      .wr_data(hwdata[7:0]),
      .restore(nv_restore),
      .restore_data(nv_image[1]),
      .q(ctl[1]),
      .next_q(next_ctl[1])
   );

   // the store saves exactly what software sees
   assign nv_save = ctl;

   // ---------------------------------------------------------------
   // driver decode per channel
   // ---------------------------------------------------------------
   for (genvar g = 0; g < 2; g++) begin : g_chan
      odc_cfg_if cfg ();
      assign cfg.fmt = ctl[g][`ODC_SEL_HI:`ODC_SEL_LO];
      assign cfg.mode1 = ctl[g][`ODC_M1_HI:`ODC_M1_LO];
      assign cfg.mode2 = ctl[g][`ODC_M2_HI:`ODC_M2_LO];
      odc_drv_decode u_dec (
         .hclk(hclk),
         .hresetn(hresetn),
         .cfg(cfg),
         .drv(drv[g])
      );
   end

   // the shared path powerdown alone leaves the buffers on; only both
   // formats at zero shut the whole pair down
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pair_fully_off <= 1'b0;
      end else begin
         pair_fully_off <= (ctl[0][`ODC_SEL_HI:`ODC_SEL_LO] == ODC_FMT_OFF) &&
            (ctl[1][`ODC_SEL_HI:`ODC_SEL_LO] == ODC_FMT_OFF);
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   // marks the first clock after reset release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seen_clock <= 1'b0;
      end else begin
         seen_clock <= 1'b1;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_RESET_SEL: assert property (!seen_clock |->
      ctl[0][6:5] == 2'h1 && ctl[1][6:5] == 2'h1)
      else $error("format select did not reset to 1");
   AST_CH1_SEL_WR: assert property (wr_hit[1] |=>
      ctl[1][6:5] == $past(hwdata[6:5]))
      else $error("channel 1 format select write lost");
   AST_CH0_M1_WR: assert property (wr_hit[0] |=>
      ctl[0][4:3] == $past(hwdata[4:3]) ##1
      (drv[0].fmt != ODC_FMT_CMOS || drv[0].leg_p.powered == $past(ctl[0][4])))
      else $error("channel 0 first mode write lost");
   AST_CH0_M2_RD: assert property (
      (addr_take && !hwrite && haddr == ADDR_OUT0 && !(wr_hit[0] || nv_restore)) |=>
      hrdata[2:1] == $past(ctl[0][2:1]))
      else $error("channel 0 second mode read back wrong");
   AST_CH1_M1_RESET: assert property (!seen_clock |->
      ctl[1][4:3] == 2'h2 && ctl[1][2:1] == 2'h0)
      else $error("channel 1 mode fields reset wrong");
   AST_CH1_M2_WR: assert property (wr_hit[1] |=>
      ctl[1][2:1] == $past(hwdata[2:1]))
      else $error("channel 1 second mode write lost");
   AST_CH0_RSV7: assert property ((!seen_clock |-> ctl[0][7]) and
      (wr_hit[0] |=> ctl[0][7] == $past(hwdata[7])))
      else $error("channel 0 bit 7 reset or write wrong");
   AST_RSV_ZERO: assert property (dp_read |->
      hrdata[31:8] == 24'h000000 && !ctl[0][0] && !ctl[1][0] && !ctl[1][7])
      else $error("reserved bit not zero");
   AST_CH0_SEL_DRV: assert property (wr_hit[0] |-> ##2
      drv[0].fmt == odc_format_t'($past(hwdata[6:5], 2)))
      else $error("channel 0 format not passed to the driver in two cycles");
   AST_OFF_PAIR: assert property ((ctl[0][6:5] == 2'h0 && ctl[1][6:5] == 2'h0) |=>
      pair_fully_off)
      else $error("pair shutdown flag missing");
   // the flag must drop again once either format comes back on
   AST_PAIR_ON: assert property ((ctl[0][6:5] != 2'h0 || ctl[1][6:5] != 2'h0) |=>
      !pair_fully_off)
      else $error("pair shutdown flag stuck high");

   // ---------------------------------------------------------------
   // checks on the bus side and the store port
   // ---------------------------------------------------------------
   // read data holds through the data phase and until the next read
   AST_RDATA_HOLD: assert property (!(addr_take && !hwrite) |=>
      $stable(hrdata))
      else $error("read data changed without a read");
   // a channel 1 read returns the whole register, reserved bits clear
   AST_CH1_RD: assert property (
      (addr_take && !hwrite && haddr == ADDR_OUT1 && !(wr_hit[1] || nv_restore)) |=>
      hrdata == {24'h000000, $past(ctl[1])})
      else $error("channel 1 read back wrong");
   // a write to no register leaves both untouched
   AST_STRAY_WR: assert property ((dp_write && wr_hit == 2'b00 && !nv_restore) |=>
      ctl == $past(ctl))
      else $error("stray write changed a register");
   // restore passes the same masks as a bus write
   AST_NV_CH0: assert property ((nv_restore && !wr_hit[0]) |=>
      ctl[0] == ($past(nv_image[0]) & `ODC_WMASK_OUT0))
      else $error("channel 0 restore wrong");
   AST_NV_CH1: assert property ((nv_restore && !wr_hit[1]) |=>
      ctl[1] == ($past(nv_image[1]) & `ODC_WMASK_OUT1))
      else $error("channel 1 restore wrong");

   // ---------------------------------------------------------------
   // checks on the decoded driver settings, one cycle behind ctl
   // ---------------------------------------------------------------
   // a disabled channel asks nothing of its driver
   AST_CH0_OFF_DRV: assert property ((ctl[0][6:5] == 2'h0) |=>
      drv[0] == '0)
      else $error("disabled channel 0 still has driver settings");
   // no tail current in the single-ended format
   AST_CH0_TAIL_CMOS: assert property ((ctl[0][6:5] == 2'h3) |=>
      drv[0].tail_ma == 5'h00)
      else $error("channel 0 tail current set in cmos");
   // the negative leg follows the second mode field in cmos
   AST_CH0_LEG_N: assert property ((ctl[0][6:5] == 2'h3) |=>
      drv[0].leg_n.powered == $past(ctl[0][2]) &&
      drv[0].leg_n.drive_en == ($past(ctl[0][2:1]) != 2'h0) &&
      drv[0].leg_n.invert == ($past(ctl[0][2:1]) == 2'h2))
      else $error("channel 0 negative leg decode wrong");
   // code 3 powers the positive leg with true polarity
   AST_CH0_LEG_P_UP: assert property ((ctl[0][6:5] == 2'h3 && ctl[0][4:3] == 2'h3) |=>
      drv[0].leg_p == 3'b110)
      else $error("channel 0 positive leg decode wrong");
   AST_CH0_LOAD: assert property ((ctl[0][6:5] == 2'h2 && ctl[0][2:1] == 2'h2) |=>
      drv[0].load_ohm == `ODC_OHM_100)
      else $error("channel 0 hcsl load decode wrong");
   // channel 1 decodes exactly as channel 0 does
   AST_CH1_TAIL6: assert property ((ctl[1][6:5] == 2'h1 && ctl[1][4:3] == 2'h1) |=>
      drv[1].tail_ma == `ODC_MA_6)
      else $error("channel 1 tail current decode wrong");
   // code 1 powers the leg down but still drives it low
   AST_CH1_LEG_P_LOW: assert property ((ctl[1][6:5] == 2'h3 && ctl[1][4:3] == 2'h1) |=>
      drv[1].leg_p == 3'b010)
      else $error("channel 1 positive leg decode wrong");
   // a load setting only exists in hcsl
   AST_CH1_LOAD_OFF: assert property ((ctl[1][6:5] != 2'h2) |=>
      drv[1].load_ohm == 8'h00)
      else $error("channel 1 load set outside hcsl");
   AST_CH1_LOAD200: assert property ((ctl[1][6:5] == 2'h2 && ctl[1][2:1] == 2'h3) |=>
      drv[1].load_ohm == `ODC_OHM_200)
      else $error("channel 1 hcsl load decode wrong");
   // both legs stay off in the two differential formats
   AST_CH1_LEGS_DIFF: assert property ((ctl[1][6] != ctl[1][5]) |=>
      drv[1].leg_p == 3'b000 && drv[1].leg_n == 3'b000)
      else $error("channel 1 legs on in a differential format");

endmodule

`default_nettype wire

// ===== odc_tb.sv
/*
 Self-checking bench for the output driver configuration bank: bus reads and
 writes, reserved bits, unmapped addresses, driver decode, nonvolatile restore.
 Assumes the design files and odc_defines.svh are compiled and included first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "odc_defines.svh"

module testbench;
   import odc_pkg::*;

   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic hclk, hresetn, hsel, hwrite, nv_restore, hreadyout, hresp, pair_fully_off;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [1:0][7:0] nv_image, nv_save;
   odc_drive_t [1:0] drv;
   logic [7:0] cur [2];
   int error_cnt, n_checks;

   // the single slave's hreadyout is the bus's hready
   odc_out_driver_regs u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .nv_restore(nv_restore), .nv_image(nv_image), .nv_save(nv_save),
      .drv(drv), .pair_fully_off(pair_fully_off)
   );

   // 100 MHz clock
   initial begin
      hclk = 1'b0;
   end
   always #5 hclk = ~hclk;

   // ---------------------------------------------------------------
   // reporting and bus tasks
   // ---------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // bounded wait for hready at a rising edge; a hung slave ends the run
   task automatic wait_rdy();
      int n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready_ok() == 1'b0 && n < 50);
      if (hready_ok() == 1'b0) begin
         error_cnt++;
         $display("Error at %0t: bus wait ran out", $time);
         wrap_up();
      end
   endtask

   function automatic logic hready_ok();
      return (hreadyout === 1'b1);
   endfunction

   // one single word transfer: address phase, then data phase
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [7:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= `ODC_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= {24'h000000, wd};
      wait_rdy();
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0, "response");
   endtask

   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
      logic [31:0] v;
      ahb(1'b0, a, 8'h00, v);
      chk(v, exp, what);
   endtask

   // ---------------------------------------------------------------
   // expected decode, worked out independently of the design
   // ---------------------------------------------------------------
   function automatic odc_leg_t leg_of(logic [1:0] m);
      case (m)
         2'h0: return 3'b000;
         2'h1: return 3'b010;
         2'h2: return 3'b111;
         default: return 3'b110;
      endcase
   endfunction

   function automatic odc_drive_t exp_drv(logic [7:0] r);
      odc_drive_t d;
      logic [1:0] f, m1, m2;
      f = r[6:5];
      m1 = r[4:3];
      m2 = r[2:1];
      d = '0;
      d.fmt = odc_format_t'(f);
      if (f == 2'h1 || f == 2'h2) begin
         d.tail_ma = (m1 == 2'h0) ? 5'h04 : (m1 == 2'h1) ? 5'h06 :
                     (m1 == 2'h2 || f == 2'h1) ? 5'h08 : 5'h10;
      end
      if (f == 2'h2) begin
         d.load_ohm = (m2 == 2'h1) ? 8'h32 : (m2 == 2'h2) ? 8'h64 :
                      (m2 == 2'h3) ? 8'hc8 : 8'h00;
      end
      if (f == 2'h3) begin
         d.leg_p = leg_of(m1);
         d.leg_n = leg_of(m2);
      end
      return d;
   endfunction

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   // reset is asserted on an edge so it also works in mid-run; the decode
   // loads at the first edge after release, so look only after the second
   task automatic do_reset();
      hresetn <= 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
   endtask

   task automatic t_reset_values();
      chk(32'(drv[0]), 32'(exp_drv(8'hb0)), "ch0 decode at reset");
      chk(32'(drv[1]), 32'(exp_drv(8'h30)), "ch1 decode at reset");
      chk({16'h0, nv_save}, 32'h000030b0, "stored image at reset");
      rd_chk(`ODC_ADDR_OUT0, 32'h000000b0, "ch0 reset value");
      rd_chk(`ODC_ADDR_OUT1, 32'h00000030, "ch1 reset value");
   endtask

   // writable and fixed reserved bits, back to back with reads
   task automatic t_reserved();
      wr(`ODC_ADDR_OUT0, 8'hff);
      rd_chk(`ODC_ADDR_OUT0, 32'h000000fe, "ch0 all ones");
      wr(`ODC_ADDR_OUT1, 8'hff);
      rd_chk(`ODC_ADDR_OUT1, 32'h0000007e, "ch1 all ones");
      wr(`ODC_ADDR_OUT0, 8'h00);
      rd_chk(`ODC_ADDR_OUT0, 32'h00000000, "ch0 all zeros");
   endtask

   // stray writes must not reach either register
   task automatic t_unmapped();
      wr(32'h00000084, 8'hff);
      wr(32'h0000017c, 8'hff);
      rd_chk(32'h00000084, 32'h00000000, "unmapped read");
      rd_chk(`ODC_ADDR_OUT0, 32'h00000000, "ch0 after stray write");
      rd_chk(`ODC_ADDR_OUT1, 32'h0000007e, "ch1 after stray write");
   endtask

   // every format and mode code on both channels; the other channel stays off
   task automatic t_decode();
      logic [31:0] a;
      logic [7:0] v;
      cur[0] = 8'h00;
      cur[1] = 8'h00;
      wr(`ODC_ADDR_OUT1, 8'h00);
      for (int ch = 0; ch < 2; ch++) begin
         a = (ch == 0) ? `ODC_ADDR_OUT0 : `ODC_ADDR_OUT1;
         for (int c = 0; c < 64; c++) begin
            v = {1'b0, 6'(c), 1'b0};
            cur[ch] = v;
            wr(a, v);
            repeat (2) @(posedge hclk);
            chk(32'(drv[ch]), 32'(exp_drv(v)), "driver decode");
            chk({31'h0, pair_fully_off}, {31'h0, (cur[0][6:5] == 2'h0 &&
                cur[1][6:5] == 2'h0)}, "pair off flag");
            rd_chk(a, {24'h0, v}, "field readback");
         end
         wr(a, 8'h00);
         cur[ch] = 8'h00;
      end
   endtask

   // restore from the nonvolatile image applies the write masks
   task automatic t_nv();
      nv_image <= {8'hff, 8'h55};
      nv_restore <= 1'b1;
      @(posedge hclk);
      nv_restore <= 1'b0;
      @(posedge hclk);
      @(posedge hclk);
      chk({16'h0, nv_save}, 32'h00007e54, "stored image after restore");
      rd_chk(`ODC_ADDR_OUT0, 32'h00000054, "ch0 after restore");
      rd_chk(`ODC_ADDR_OUT1, 32'h0000007e, "ch1 after restore");
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      error_cnt = 0;
      n_checks = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      nv_restore = 1'b0;
      nv_image = 16'h0000;
      @(posedge hclk);
      do_reset();
      t_reset_values();
      t_reserved();
      t_unmapped();
      t_decode();
      t_nv();
      // a second reset in mid-run must bring the reset values back
      do_reset();
      t_reset_values();
      wrap_up();
   end

endmodule

`default_nettype wire
